// ==== test/hrs_chk.sv ====
// checker: link status and latched strap relations at the top ports
`timescale 1ns/1ps
module hrs_chk
    import hrs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire hrs_speed_t link_speed,
    input wire logic super_speed_link_status,
    input wire logic high_speed_link_status,
    input wire logic port0_power_enable_out,
    input wire logic full_power_mgmt,
    input wire logic gang_mode,
    input wire logic indicator_led_enable,
    input wire logic smbus_mode,
    input wire logic [6:0] smbus_slave_addr
);
    logic [3:0] cnt;
    logic on;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // edges since release, saturating so long runs do not wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
        end
    end
    assign on = cnt > 4'h6;  // decode settled, well past the latch edge
    ss_status_a: assert property ($past(aresetn) |->
        super_speed_link_status == ($past(link_speed) == HRS_SPEED_SS)) else $error("ss status wrong");
    hs_status_a: assert property ($past(aresetn) |->
        high_speed_link_status == ($past(link_speed) == HRS_SPEED_HS)) else $error("hs status wrong");
    pwr_forced_a: assert property (on && !full_power_mgmt |->
        port0_power_enable_out) else $error("power off");
    pwr_early_a: assert property (cnt < 4'h3 |-> !port0_power_enable_out) else $error("power early");
    addr_one_a: assert property (on && smbus_mode |->
        smbus_slave_addr[1] == !full_power_mgmt) else $error("bit1");
    addr_two_a: assert property (on && smbus_mode |->
        smbus_slave_addr[2] == gang_mode) else $error("bit2");
    addr_three_a: assert property (on && smbus_mode |->
        smbus_slave_addr[3] == !indicator_led_enable) else $error("bit3");
    strap_hold_a: assert property (on |->
        $stable({full_power_mgmt, gang_mode, indicator_led_enable, smbus_mode, smbus_slave_addr})) else $error("moved");
    cover property (super_speed_link_status);
    cover property (on && smbus_mode);
    cover property (on && full_power_mgmt);
endmodule : hrs_chk
bind hrs_top hrs_chk chk (.*);

// ==== test/hrs_partner.sv ====
// board strap resistors and upstream host model
`timescale 1ns/1ps
module hrs_partner
    import hrs_pkg::*;
(
    input wire logic aclk,
    input wire logic [3:0] fitted,
    input wire hrs_speed_t host_speed,
    output logic [3:0] straps,
    output hrs_speed_t link_speed
);
    // an unfitted strap floats to its pull-up level
    assign straps = ~fitted;
    // the link core reports the negotiated speed on the core clock
    always_ff @(posedge aclk) begin
        link_speed <= host_speed;
    end
endmodule : hrs_partner

// ==== test/tb_hub_reset_straps_and_status.sv ====
// self-checking bench: strap decode and hold, link status, axi4-lite access
`timescale 1ns/1ps
module tb_hub_reset_straps_and_status;
    import hrs_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, port_power_request = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic port_power_ctrl_strap_addr1, gang_strap_addr2, indicator_led_strap_addr3, smbus_mode_select_strap;
    logic super_speed_link_status, high_speed_link_status, port0_power_enable_out, full_power_mgmt;
    logic gang_mode, indicator_led_enable, smbus_mode, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [6:0] smbus_slave_addr;
    logic [3:0] s_axi_wstrb = 4'hf, fit = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    hrs_speed_t link_speed, host_speed = HRS_SPEED_LS_FS;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #12.5 aclk = ~aclk;
    hrs_partner board (.aclk(aclk), .fitted(fit), .host_speed(host_speed), .link_speed(link_speed),
        .straps({smbus_mode_select_strap, indicator_led_strap_addr3, gang_strap_addr2, port_power_ctrl_strap_addr1}));
    hrs_top uut (.*);
    task final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // a hang ends the run through the same report
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", n, exp, seen);
        end
    endtask : check
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w) begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'h0;
            if (s_axi_wready) w = 1'h0;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'h0;
        rs = s_axi_bresp;
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : rd_reg
    // reset with one strap set, then move the pins: the latched set must not follow
    task automatic run_set(input logic [3:0] pd);
        logic [3:0] p;
        p = ~pd;
        fit <= pd;
        aresetn <= 1'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (8) @(posedge aclk);
        fit <= 4'($urandom);
        repeat (6) @(posedge aclk);
        rd_reg(REG_STATUS);
        check("status", rd, {25'h0, 1'h1, p[3], !p[2], p[1], !p[0], 2'h0});
        rd_reg(REG_ADDR);
        check("addr", rd, {25'h0, SMB_ADDR_BASE | (p[3] ? {3'h0, p[2:0], 1'h0} : 7'h0)});
        check("port0", {31'h0, port0_power_enable_out}, {31'h0, p[0]});
        // the decoded configuration pins must agree with the latched straps as well
        check("pins", {21'h0, smbus_slave_addr, smbus_mode, indicator_led_enable, gang_mode, full_power_mgmt},
            {21'h0, SMB_ADDR_BASE | (p[3] ? {3'h0, p[2:0], 1'h0} : 7'h0), p[3], !p[2], p[1], !p[0]});
    endtask : run_set
    initial begin
        void'($urandom(32'h48baa58d));
        for (int i = 0; i < 8; i++) run_set(i == 0 ? 4'h0 : i == 1 ? 4'hf : 4'($urandom));
        run_set(4'h1);
        for (int s = 0; s < 3; s++) begin
            host_speed <= hrs_speed_t'(s);
            repeat (3) @(posedge aclk);
            rd_reg(REG_STATUS);
            check("speed", {28'h0, super_speed_link_status, high_speed_link_status, rd[ST_SS], rd[ST_HS]},
                {28'h0, 1'(s == 2), 1'(s == 1), 1'(s == 2), 1'(s == 1)});
        end
        port_power_request <= 1'h1;
        repeat (3) @(posedge aclk);
        check("request", {31'h0, port0_power_enable_out}, 32'h1);
        port_power_request <= 1'h0;
        wr(REG_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        check("ctrl on", {30'h0, rs, port0_power_enable_out}, {30'h0, RESP_OKAY, 1'h1});
        wr(REG_CTRL, 32'h0);
        repeat (2) @(posedge aclk);
        check("ctrl off", {31'h0, port0_power_enable_out}, 32'h0);
        rd_reg(8'h0c);
        check("unmapped", {rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
        final_report();
    end
endmodule : tb_hub_reset_straps_and_status

// ==== verilog/hrs_pkg.sv ====
// package: register map, field positions, reset values and types for the strap/status block
package hrs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;  // read: link status and latched straps
    localparam logic [7:0] REG_CTRL = 8'h04;    // read/write: downstream power request
    localparam logic [7:0] REG_ADDR = 8'h08;    // read: smbus slave address bits
    // status field positions
    localparam int ST_SS = 0;
    localparam int ST_HS = 1;
    localparam int ST_PWR = 2;
    localparam int ST_GANG = 3;
    localparam int ST_LED = 4;
    localparam int ST_SMB = 5;
    localparam int ST_VALID = 6;
    // control field positions and reset
    localparam int CT_PWR = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // smbus address fixed bits and reset of the address register
    localparam logic [6:0] SMB_ADDR_BASE = 7'h40;  // bits outside 3:1 are arbitrary
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // upstream link speed as reported by the link core
    typedef enum logic [1:0] {
        HRS_SPEED_LS_FS,
        HRS_SPEED_HS,
        HRS_SPEED_SS
    } hrs_speed_t;
    // latched strap set
    typedef struct packed {
        logic smbus_mode;
        logic power_ctrl;
        logic gang;
        logic led;
    } hrs_straps_t;
endpackage : hrs_pkg

// ==== verilog/hrs_strap_latch.sv ====
// strap sampler: synchronises strap pins and latches them once after reset release
`timescale 1ns/1ps
module hrs_strap_latch
    import hrs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] strap_pins,
    output hrs_straps_t straps,
    output logic valid
);
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] settle;

    // two-stage synchroniser; pins are board straps, asynchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= strap_pins;
            sync2 <= sync1;
        end
    end

    // wait until the synchroniser holds post-release samples, then latch once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle <= 2'h0;
            valid <= 1'b0;
            straps <= '0;
        end else if (!valid) begin
            settle <= settle + 2'h1;
            if (settle == 2'h2) begin
                valid <= 1'b1;
                straps <= hrs_straps_t'(sync2); // RULE3 RULE6 RULE8
            end
        end
        // once valid, later pin changes are ignored until the next reset  RULE10
    end
endmodule : hrs_strap_latch

// ==== verilog/hrs_top.sv ====
// top: upstream link-status outputs, strap configuration and an axi4-lite status port
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// RULE1: superspeed status pin high only in superspeed
// RULE2: high-speed status pin high only at high-speed
// RULE3: power-control strap 0 means full management
// RULE4: full management drives port zero power enable
// RULE5: smbus mode: address bit 1 from power strap
// RULE6: gang strap 1 means ganged power switching
// RULE7: smbus mode: address bit 2 from gang strap
// RULE8: indicator strap 0 enables port leds
// RULE9: smbus mode: address bit 3 from indicator strap
// RULE10: straps latched at release, held until reset
module hrs_top
    import hrs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire hrs_speed_t link_speed,
    input wire logic port_power_request,
    input wire logic port_power_ctrl_strap_addr1,
    input wire logic gang_strap_addr2,
    input wire logic indicator_led_strap_addr3,
    input wire logic smbus_mode_select_strap,
    output logic super_speed_link_status,
    output logic high_speed_link_status,
    output logic port0_power_enable_out,
    output logic full_power_mgmt,
    output logic gang_mode,
    output logic indicator_led_enable,
    output logic smbus_mode,
    output logic [6:0] smbus_slave_addr,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    hrs_straps_t straps;
    logic straps_valid;
    logic [31:0] ctrl;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [6:0] next_addr;

    hrs_strap_latch u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .strap_pins({smbus_mode_select_strap, port_power_ctrl_strap_addr1,
                     gang_strap_addr2, indicator_led_strap_addr3}),
        .straps(straps),
        .valid(straps_valid)
    );

    // link status pins follow the link core speed; link_speed is same-clock logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            super_speed_link_status <= 1'b0;
            high_speed_link_status <= 1'b0;
        end else begin
            super_speed_link_status <= (link_speed == HRS_SPEED_SS); // RULE1
            high_speed_link_status <= (link_speed == HRS_SPEED_HS); // RULE2
        end
    end

    // smbus address: straps fill bits 3:1 in smbus mode, otherwise base value
    always_comb begin
        next_addr = SMB_ADDR_BASE;
        if (straps.smbus_mode) begin
            next_addr[1] = straps.power_ctrl; // RULE5
            next_addr[2] = straps.gang; // RULE7
            next_addr[3] = straps.led; // RULE9
        end
    end

    // decoded configuration; held low, address at SMB_ADDR_BASE, until the straps are latched
    // smbus_mode_select_strap is taken active high here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full_power_mgmt <= 1'b0;
            gang_mode <= 1'b0;
            indicator_led_enable <= 1'b0;
            smbus_mode <= 1'b0;
            smbus_slave_addr <= SMB_ADDR_BASE;
            port0_power_enable_out <= 1'b0;
        end else if (straps_valid) begin
            full_power_mgmt <= !straps.power_ctrl; // RULE3
            gang_mode <= straps.gang; // RULE6
            indicator_led_enable <= !straps.led; // RULE8
            smbus_mode <= straps.smbus_mode;
            smbus_slave_addr <= next_addr;
            // without full management downstream power is simply left on
            port0_power_enable_out <= straps.power_ctrl ? 1'b1
                                     : (port_power_request | ctrl[CT_PWR]); // RULE4
        end
    end

    // write channel: address and data accepted independently, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl <= CTRL_RESET;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr[7:2] == REG_CTRL[7:2]) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (w_strb[0]) begin
                        ctrl[7:0] <= w_data[7:0] & 8'h01;  // only the power bit exists
                    end
                end else if (aw_addr[7:2] == REG_STATUS[7:2] || aw_addr[7:2] == REG_ADDR[7:2]) begin
                    s_axi_bresp <= RESP_OKAY;  // read-only: write ignored
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one outstanding read, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                unique case (s_axi_araddr[7:2])
                    REG_STATUS[7:2]: begin
                        s_axi_rdata[ST_SS] <= super_speed_link_status;
                        s_axi_rdata[ST_HS] <= high_speed_link_status;
                        s_axi_rdata[ST_PWR] <= full_power_mgmt;
                        s_axi_rdata[ST_GANG] <= gang_mode;
                        s_axi_rdata[ST_LED] <= indicator_led_enable;
                        s_axi_rdata[ST_SMB] <= smbus_mode;
                        s_axi_rdata[ST_VALID] <= straps_valid;
                    end
                    REG_CTRL[7:2]: s_axi_rdata <= ctrl;
                    REG_ADDR[7:2]: s_axi_rdata[6:0] <= smbus_slave_addr;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : hrs_top
